// *** bench/rtc_trim_output_select_bench.sv ***
// Self-checking register bench for the trim / output select block.
// Assumes shortened second (16 pulses) and divider (4 / 5) parameters.
`timescale 1ns/100ps
module rtc_trim_output_select_bench;
    import rtcts_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sys_rst = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h3;
    logic [31:0] wd = 32'h0;
    logic        osc = 1'b1;
    logic        alarm = 1'b0;
    logic [31:0] rdat;
    logic        ack, pin, pin_oe, buf_ty, half, en;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          t0, g, adj;
    logic [7:0]  codes [5] = '{8'h00, 8'h01, 8'h7F, 8'hFF, 8'h80};
    always #5 clk_i = ~clk_i;
    rtcts_top #(.TICKS_PER_SEC_P(16'h0010), .SECONDARY_OSC_DIV_P(4), .INTERNAL_LOW_POWER_OSC_DIV_P(5)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_ack_o(ack), .oscillator_choice_i(osc), .alarm_pulse_i(alarm), .clock_pin_o(pin),
        .clock_pin_oe_o(pin_oe), .parallel_port_buffer_type_o(buf_ty),
        .half_second_flag_o(half), .module_enable_bit_o(en));
    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ceiling sized for all five trim codes plus margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {16'h0000, d};
        // No limit here: the bench timeout ends a wait that never sees ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        check(q & m, exp);
    endtask
    task automatic wait_half(input logic v);
        int n;
        n = 0;
        while (half !== v && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
    endtask
    // Second count is the full spacing between two pin edges
    task automatic gap(output int c);
        logic p;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            p = pin;
            do begin
                @(posedge clk_i);
                c++;
            end while (pin === p && c < 50);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_TRIM, 32'h0, 32'hFFFF_FFFF);
        rd(OFS_ALARM, 32'h0, 32'hFFFF_FFFF);
        wr(OFS_ALARM, 16'hFFFF);
        rd(OFS_ALARM, 32'h0000_FFFF, 32'hFFFF_FFFF);
        wr(OFS_PAD, 16'hFFF9);
        rd(OFS_PAD, 32'h1, 32'hFFFF_FFFF);
        check({31'h0, buf_ty}, 32'h1);
        wr(8'h10, 16'hFFFF);
        rd(8'h10, 32'h0, 32'hFFFF_FFFF);
        wr(OFS_TRIM, 16'h8C00);
        check({30'h0, en, pin_oe}, 32'h1);
        wr(OFS_TRIM, 16'h2400);
        wr(OFS_TRIM, 16'hA400);
        rd(OFS_TRIM, 32'hA400, 32'hF7FF);
        sys_rst <= 1'b1;
        @(posedge clk_i);
        sys_rst <= 1'b0;
        @(posedge clk_i);
        check({30'h0, en, buf_ty}, 32'h2);
        alarm <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, pin}, 32'h1);
        alarm <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0, pin}, 32'h0);
        wr(OFS_PAD, 16'h0002);
        wait_half(1'b1);
        check({31'h0, pin}, 32'h1);
        wait_half(1'b0);
        check({31'h0, pin}, 32'h0);
        wr(OFS_PAD, 16'h0004);
        gap(g);
        check(g, 32'd4);
        osc <= 1'b0;
        gap(g);
        gap(g);
        check(g, 32'd5);
        osc <= 1'b1;
        // Sample 2 and 12 pulses into second 44 so a 4-pulse error shows
        for (int i = 0; i < 5; i++) begin
            wr(OFS_MINUTES_SECONDS_VALUE, {8'h00, LAST_SEC});
            t0 = cycles;
            check({31'h0, half}, 32'h0);
            wr(OFS_TRIM, {8'hA4, codes[i]});
            adj = 4 * int'($signed(codes[i]));
            for (int j = 0; j < 2; j++) begin
                while (cycles < t0 + 4 * (722 + 10 * j - adj)) @(posedge clk_i);
                check({31'h0, half}, {31'h0, j[0]});
                rd(OFS_MINUTES_SECONDS_VALUE, 32'h012C, 32'hFFFF);
            end
        end
        // Upper lane only: minutes load, the running second and its flag stay
        sel <= 4'h2;
        wr(OFS_MINUTES_SECONDS_VALUE, 16'h0500);
        sel <= 4'h3;
        check({31'h0, half}, 32'h1);
        rd(OFS_MINUTES_SECONDS_VALUE, 32'h0500, 32'hFF00);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_TRIM, 32'h0, 32'hFFFF_FFFF);
        tally_and_finish();
    end
endmodule

// *** bench/rtcts_chk.sv ***
// Port-level properties of the trim / output select block.
// Assumes a Wishbone master that holds each request until it sees ack.
`timescale 1ns/100ps
module rtcts_chk
    import rtcts_pkg::*;
(
    input logic        clk_i,
    input logic        rst_i,
    input logic        sys_reset_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        clock_pin_o,
    input logic        clock_pin_oe_o,
    input logic        parallel_port_buffer_type_o,
    input logic        half_second_flag_o,
    input logic        module_enable_bit_o
);
    logic unlock_q;
    logic req;
    logic trim_wr;
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !sys_reset_i;
    assign trim_wr = req && wb_we_i && wb_sel_i[1] && wb_adr_i[7:2] == OFS_TRIM[7:2];
    // Unlock bit is not on any port, so shadow it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_q <= 1'b0;
        end else if (trim_wr) begin
            unlock_q <= wb_dat_i[TRIM_UNLOCK_BIT];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [7:0] ofs);
        req && wb_we_i && wb_adr_i[7:2] == ofs[7:2];
    endsequence
    ack_single_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_latency_a:
        assert property (req |=> wb_ack_o) else $error("request not acked in one cycle");
    pad_zero_bits_a:
        assert property (req && !wb_we_i && wb_adr_i[7:2] == OFS_PAD[7:2]
            |=> wb_dat_o[31:3] == 29'h0) else $error("pad register upper bits set");
    buffer_type_a:
        assert property (s_wr(OFS_PAD) ##0 wb_sel_i[0]
            |=> parallel_port_buffer_type_o == $past(wb_dat_i[0])) else $error("buffer type");
    enable_lock_a:
        assert property (trim_wr |=> module_enable_bit_o == ($past(unlock_q) ?
            $past(wb_dat_i[15]) : $past(module_enable_bit_o))) else $error("enable lock");
    enable_cause_a:
        assert property (!$past(rst_i) && !$stable(module_enable_bit_o) |-> $past(trim_wr))
            else $error("enable changed without a write");
    // Pin enable passes through the trim register and then the pin stage
    output_enable_a:
        assert property (trim_wr |=> ##1 clock_pin_oe_o == $past(wb_dat_i[TRIM_OE_BIT], 2))
            else $error("pin enable not loaded");
    half_clear_a:
        assert property (s_wr(OFS_MINUTES_SECONDS_VALUE) ##0 (wb_sel_i[0] && unlock_q)
            |=> !half_second_flag_o) else $error("half flag not cleared");
    sys_reset_keep_a:
        assert property (sys_reset_i |=> $stable(module_enable_bit_o) &&
            $stable(clock_pin_oe_o) && !parallel_port_buffer_type_o) else $error("sys reset");
    pin_quiet_a:
        assert property (!clock_pin_oe_o [*2] |-> !clock_pin_o) else $error("pin driven");
endmodule

bind rtcts_top rtcts_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .clock_pin_o(clock_pin_o), .clock_pin_oe_o(clock_pin_oe_o),
    .parallel_port_buffer_type_o(parallel_port_buffer_type_o),
    .half_second_flag_o(half_second_flag_o), .module_enable_bit_o(module_enable_bit_o));

// *** rtl/rtcts_pin_mux.sv ***
// Registered source select for the calendar clock output pin.
// Assumes all inputs are synchronous enables or levels on clk_i.
`timescale 1ns/100ps
module rtcts_pin_mux
    import rtcts_pkg::*;
(
    input  logic       clk_i,
    input  logic       rst_i,
    input  logic [1:0] sel_i,
    input  logic       oe_i,
    input  logic       src_tick_i,
    input  logic       sec_clk_i,
    input  logic       alarm_pulse_i,
    output logic       pin_o,
    output logic       pin_oe_o
);
    logic src_clk;
    logic next_pin;

    always_comb begin
        case (sel_i)
            PIN_SEL_SRC:   next_pin = src_clk;
            PIN_SEL_SEC:   next_pin = sec_clk_i;
            PIN_SEL_ALARM: next_pin = alarm_pulse_i;
            default:       next_pin = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_clk  <= 1'b0;
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            // Source clock rebuilt at half the tick rate, one edge per tick
            if (src_tick_i) begin
                src_clk <= ~src_clk;
            end
            pin_o    <= next_pin & oe_i;
            pin_oe_o <= oe_i;
        end
    end
endmodule

// *** rtl/rtcts_pkg.sv ***
// Constants, register map and field layout of the drift-trim / output-select block.
// Assumes a 100 MHz system clock and classic Wishbone register access.
// Operation
// - Code 0x7F adds 508 pulses per minute
// - Code 0x01 adds 4 pulses per minute
// - Code 0xFF removes 4 pulses per minute
// - Code 0x80 removes 512 pulses per minute
// - Trim register cleared only by power-on reset
// - Enable bit writable only while unlock set
// - Half-second flag read-only, cleared by seconds write
// - Half-second flag high in second half
// - Select 10 drives pin with source clock
// - Select 01 drives pin with seconds clock
// - Select 00 drives pin with alarm pulse
// - Select at bits 2:1, bits 15:3 zero
// - Bit 0 picks TTL or Schmitt buffers
package rtcts_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned SECONDARY_OSC_HZ        = 32768;
    localparam int unsigned INTERNAL_LOW_POWER_OSC_HZ        = 31000;
    localparam int unsigned SECONDARY_OSC_DIV       = CLK_HZ / SECONDARY_OSC_HZ;
    localparam int unsigned INTERNAL_LOW_POWER_OSC_DIV       = CLK_HZ / INTERNAL_LOW_POWER_OSC_HZ;
    localparam logic [15:0] TICKS_PER_SEC  = 16'h8000;
    localparam logic [7:0]  LAST_SEC       = 8'h3B;
    localparam int unsigned ADJ_STEP       = 4;
    // Register byte offsets
    localparam logic [7:0]  OFS_TRIM       = 8'h00;
    localparam logic [7:0]  OFS_PAD        = 8'h04;
    localparam logic [7:0]  OFS_ALARM      = 8'h08;
    localparam logic [7:0]  OFS_MINUTES_SECONDS_VALUE     = 8'h0C;
    // clock_trim_config fields
    localparam int unsigned TRIM_EN_BIT     = 15;
    localparam int unsigned TRIM_UNLOCK_BIT = 13;
    localparam int unsigned TRIM_HALF_BIT   = 11;
    localparam int unsigned TRIM_OE_BIT     = 10;
    // pad_option_control fields
    localparam int unsigned PAD_SEL_LSB    = 1;
    localparam int unsigned PAD_TTL_BIT    = 0;
    // Reset values
    localparam logic [7:0]  CAL_RST        = 8'h00;
    localparam logic [15:0] ALARM_RST      = 16'h0000;
    localparam logic [1:0]  PIN_SEL_RST    = 2'h0;
    // Clock pin source codes
    localparam logic [1:0]  PIN_SEL_ALARM  = 2'h0;
    localparam logic [1:0]  PIN_SEL_SEC    = 2'h1;
    localparam logic [1:0]  PIN_SEL_SRC    = 2'h2;
endpackage

// *** rtl/rtcts_tick_div.sv ***
// Divider giving a one-cycle enable at an oscillator's rate.
// Assumes a single system clock; DIV is at least 2.
`timescale 1ns/100ps
module rtcts_tick_div #(
    parameter int unsigned DIV = 3051
) (
    input  logic clk_i,
    input  logic rst_i,
    output logic tick_o
);
    logic [15:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt == 16'(DIV - 1)) begin
            cnt    <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// *** rtl/rtcts_top.sv ***
// Calendar clock drift trim, half-second flag, pad option and alarm setup registers.
// Assumes classic Wishbone on clk_i; rst_i is the power-on reset, sys_reset_i any other.
`timescale 1ns/100ps
module rtcts_top
    import rtcts_pkg::*;
#(
    parameter logic [15:0] TICKS_PER_SEC_P = TICKS_PER_SEC,
    parameter int unsigned SECONDARY_OSC_DIV_P      = SECONDARY_OSC_DIV,
    parameter int unsigned INTERNAL_LOW_POWER_OSC_DIV_P      = INTERNAL_LOW_POWER_OSC_DIV
) (
    input  logic        clk_i,
    input  logic        rst_i,
    input  logic        sys_reset_i,
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    input  logic        wb_we_i,
    input  logic [7:0]  wb_adr_i,
    input  logic [3:0]  wb_sel_i,
    input  logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    input  logic        oscillator_choice_i,
    input  logic        alarm_pulse_i,
    output logic        clock_pin_o,
    output logic        clock_pin_oe_o,
    output logic        parallel_port_buffer_type_o,
    output logic        half_second_flag_o,
    output logic        module_enable_bit_o
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic        module_enable_bit;
        logic        value_write_unlock;
        logic        pin_oe;
        logic [7:0]  cal;
        logic [1:0]  clock_pin_source_select;
        logic        parallel_port_buffer_type;
        logic [15:0] alarm_setup_repeat;
        logic [7:0]  minutes;
        logic [7:0]  seconds;
        logic [15:0] subsec;
        logic [9:0]  adj_left;
        logic        adj_neg;
        logic        half_second_flag;
    } rtcts_state_t;

    rtcts_state_t q;
    rtcts_state_t next_q;

    logic [1:0] osc_tick;
    logic       src_tick;

    localparam int unsigned OSC_DIVS [2] = '{INTERNAL_LOW_POWER_OSC_DIV_P, SECONDARY_OSC_DIV_P};

    // Index 0 is the internal low-power oscillator, 1 the secondary one
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_osc
            rtcts_tick_div #(
                .DIV    (OSC_DIVS[gi])
            ) u_div (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_o (osc_tick[gi])
            );
        end
    endgenerate

    assign src_tick = oscillator_choice_i ? osc_tick[1] : osc_tick[0];

    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
        reg_hit = (adr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // Signed trim code to unsigned pulse count; direction comes from cal[7]
    function automatic logic [9:0] trim_amount(input logic [7:0] cal);
        logic [9:0] mag;
        mag = cal[7] ? (({2'b00, ~cal}) + 10'h001) : {2'b00, cal};
        trim_amount = 10'(mag * ADJ_STEP);
    endfunction

    function automatic logic [15:0] trim_word(input rtcts_state_t s);
        trim_word = 16'h0000;
        trim_word[TRIM_EN_BIT]     = s.module_enable_bit;
        trim_word[TRIM_UNLOCK_BIT] = s.value_write_unlock;
        trim_word[TRIM_HALF_BIT]   = s.half_second_flag;
        trim_word[TRIM_OE_BIT]     = s.pin_oe;
        trim_word[7:0]             = s.cal;
    endfunction

    function automatic logic [15:0] pad_word(input rtcts_state_t s);
        pad_word = 16'h0000;
        pad_word[PAD_SEL_LSB +: 2] = s.clock_pin_source_select;
        pad_word[PAD_TTL_BIT]      = s.parallel_port_buffer_type;
    endfunction

    logic        access;
    logic        wr;
    logic        count;
    logic [15:0] wword;

    always_comb begin
        next_q = q;
        // Held off during the other reset so the request is applied once, after it
        access = wb_cyc_i & wb_stb_i & ~q.ack & ~sys_reset_i;
        wr     = access & wb_we_i;
        count  = 1'b0;
        wword  = 16'h0000;
        next_q.ack = access;

        // Timekeeping; a pending trim either swallows or inserts pulses
        if (q.module_enable_bit) begin
            if ((q.adj_left != 10'h000) && q.adj_neg && src_tick) begin
                next_q.adj_left = q.adj_left - 10'h001;
            end else if (src_tick) begin
                count = 1'b1;
            end else if ((q.adj_left != 10'h000) && !q.adj_neg) begin
                count           = 1'b1;
                next_q.adj_left = q.adj_left - 10'h001;
            end
        end

        if (count) begin
            if (q.subsec >= TICKS_PER_SEC_P - 16'h0001) begin
                next_q.subsec = 16'h0000;
                if (q.seconds >= LAST_SEC) begin
                    next_q.seconds = 8'h00;
                    next_q.minutes = (q.minutes >= LAST_SEC) ? 8'h00 : q.minutes + 8'h01;
                    // Once per minute the trim is reloaded
                    next_q.adj_left = trim_amount(q.cal);
                    next_q.adj_neg  = q.cal[7];
                end else begin
                    next_q.seconds = q.seconds + 8'h01;
                end
            end else begin
                next_q.subsec = q.subsec + 16'h0001;
            end
        end

        // Register writes win over the timekeeping update
        if (wr) begin
            if (reg_hit(wb_adr_i, OFS_TRIM)) begin
                wword = merge16(trim_word(q), wb_dat_i, wb_sel_i);
                next_q.cal = wword[7:0];
                if (wb_sel_i[1]) begin
                    next_q.value_write_unlock = wword[TRIM_UNLOCK_BIT];
                    next_q.pin_oe             = wword[TRIM_OE_BIT];
                    // Lock checked against the value before this write
                    if (q.value_write_unlock) begin
                        next_q.module_enable_bit = wword[TRIM_EN_BIT];
                    end
                end
            end else if (reg_hit(wb_adr_i, OFS_PAD)) begin
                wword = merge16(pad_word(q), wb_dat_i, wb_sel_i);
                next_q.clock_pin_source_select   = wword[PAD_SEL_LSB +: 2];
                next_q.parallel_port_buffer_type = wword[PAD_TTL_BIT];
            end else if (reg_hit(wb_adr_i, OFS_ALARM)) begin
                next_q.alarm_setup_repeat =
                    merge16(q.alarm_setup_repeat, wb_dat_i, wb_sel_i);
            end else if (reg_hit(wb_adr_i, OFS_MINUTES_SECONDS_VALUE) && q.value_write_unlock) begin
                if (wb_sel_i[1]) begin
                    next_q.minutes = wb_dat_i[15:8];
                end
                if (wb_sel_i[0]) begin
                    // Restarting the second keeps the flag and count aligned
                    next_q.seconds = wb_dat_i[7:0];
                    next_q.subsec  = 16'h0000;
                end
            end
        end

        // Flag follows the sub-second count, so no write can set it
        next_q.half_second_flag = (next_q.subsec >= (TICKS_PER_SEC_P >> 1));

        if (access && !wb_we_i) begin
            if (reg_hit(wb_adr_i, OFS_TRIM)) begin
                next_q.dat = {16'h0000, trim_word(q)};
            end else if (reg_hit(wb_adr_i, OFS_PAD)) begin
                next_q.dat = {16'h0000, pad_word(q)};
            end else if (reg_hit(wb_adr_i, OFS_ALARM)) begin
                next_q.dat = {16'h0000, q.alarm_setup_repeat};
            end else if (reg_hit(wb_adr_i, OFS_MINUTES_SECONDS_VALUE)) begin
                next_q.dat = {16'h0000, q.minutes, q.seconds};
            end else begin
                next_q.dat = 32'h0000_0000;
            end
        end

        // Other resets leave the trim register and its flags alone
        if (sys_reset_i) begin
            next_q.ack                       = 1'b0;
            next_q.clock_pin_source_select   = PIN_SEL_RST;
            next_q.parallel_port_buffer_type = 1'b0;
            next_q.alarm_setup_repeat        = ALARM_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q                         <= '0;
            q.cal                     <= CAL_RST;
            q.clock_pin_source_select <= PIN_SEL_RST;
            q.alarm_setup_repeat      <= ALARM_RST;
        end else begin
            q <= next_q;
        end
    end

    rtcts_pin_mux u_pin (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .sel_i         (q.clock_pin_source_select),
        .oe_i          (q.pin_oe),
        .src_tick_i    (src_tick),
        .sec_clk_i     (q.half_second_flag),
        .alarm_pulse_i (alarm_pulse_i),
        .pin_o         (clock_pin_o),
        .pin_oe_o      (clock_pin_oe_o)
    );

    assign wb_ack_o                    = q.ack;
    assign wb_dat_o                    = q.dat;
    assign parallel_port_buffer_type_o = q.parallel_port_buffer_type;
    assign half_second_flag_o          = q.half_second_flag;
    assign module_enable_bit_o         = q.module_enable_bit;
endmodule
